// *** sdt_ctrl.sv ***
// Display SDRAM control and timing-parameter registers with init and
// power-save sequencing. Assumes a one-cycle register port and a memory
// path that reports read addresses and bandwidth shortfall.
// Function
// - Latch warning near top, range, bandwidth
// - Warning readable, cleared by writing zero
// - Parameter enable bit opens timing registers
// - E0h-E3h timing only while enabled
// - Power-save bit edges enter/exit saving
// - Init bit rising launches init sequence
// - Init bit reads one once ready
// - Init bit sticky; zero write ignored
// - Mode-load delay n+1 clocks, reset 2
// - Refresh period n+1 clocks, reset 8
// - Self-refresh exit delay, reset 7
// - Precharge period, reset 2
// - Write recovery, reset 0
// - Activate delays, reset 2 and 6
// - Refresh interval spacing; zero disables
// - CAS latency locked after init done
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
module sdt_ctrl
    import sdt_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter logic [ADDR_W-1:0] MEM_TOP = 24'hFFFFFF
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rd_valid,
    input wire logic [ADDR_W-1:0] rd_addr,
    input wire logic bw_short,
    output logic [2:0] mem_cmd,
    output logic mem_cke,
    output logic mem_ready,
    output logic [3:0] t_rcd,
    output logic [3:0] t_ras,
    output logic [3:0] t_wr,
    output logic [2:0] cas_latency_select
);
    typedef struct packed {
        logic [3:0] mrd;
        logic [3:0] rfc;
        logic [3:0] xsr;
        logic [3:0] rp;
        logic [3:0] wr;
        logic [3:0] rcd;
        logic [3:0] ras;
        logic [7:0] attr;
        logic [2:0] cas;
        logic [15:0] refresh_interval;
        logic warn;
        logic timing_param_enable;
        logic mem_power_save_request;
        logic mem_init_start_ready;
        logic init_req;
        logic [15:0] ref_cnt;
        logic [1:0] aref_left;
        logic saving;
        logic [2:0] cmd;
        sdt_state_e state;
        logic [7:0] rdata;
    } sdt_ctrl_s;
    sdt_ctrl_s st_reg;
    sdt_ctrl_s st_next;
    logic dly_load;
    logic [15:0] dly_count;
    logic dly_busy;
    logic near_top;
    initial begin
        if (ADDR_W < 10 || ADDR_W > 32) $error("sdt_ctrl ADDR_W out of range");
        // Margin subtraction must not wrap
        if (MEM_TOP < ADDR_W'(WARN_MARGIN_BYTES)) $error("sdt_ctrl MEM_TOP below margin");
    end
    // Near or beyond the top minus the margin
    assign near_top = rd_addr > (MEM_TOP - ADDR_W'(WARN_MARGIN_BYTES));
    sdt_delay #(
        .W(16)
    ) u_delay (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .load(dly_load),
        .count(dly_count),
        .busy(dly_busy)
    );
    function automatic logic [7:0] rd_mux(input sdt_ctrl_s s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (s.timing_param_enable) begin
            // Timing view replaces normal registers
            unique case (a)
                OFS_TIMING1: v = {4'h0, s.mrd};
                OFS_TIMING2: v = {s.rfc, s.xsr};
                OFS_TIMING3: v = {s.rp, s.wr};
                OFS_TIMING4: v = {s.rcd, s.ras};
                default: v = 8'h00;
            endcase
        end else begin
            unique case (a)
                OFS_ATTR: v = s.attr;
                OFS_MODE: v = {5'h00, s.cas};
                OFS_REF_LO: v = s.refresh_interval[7:0];
                OFS_REF_HI: v = s.refresh_interval[15:8];
                default: v = 8'h00;
            endcase
        end
        if (a == OFS_CONTROL) begin
            // Ready shows only after init completes
            v = {4'h0, s.warn, s.timing_param_enable, s.mem_power_save_request,
                s.mem_init_start_ready};
        end
        if (a == OFS_STATUS) begin
            v = {2'h0, s.state};
        end
        return v;
    endfunction
    always_comb begin
        st_next = st_reg;
        dly_load = 1'b0;
        dly_count = 16'h0000;
        st_next.cmd = SDT_CMD_NOP;
        st_next.rdata = 8'h00;
        if (reg_rd) begin
            st_next.rdata = rd_mux(st_reg, reg_addr);
        end
        if (reg_wr) begin
            if (st_reg.timing_param_enable) begin
                // Field encodings n+1 applied at use
                unique case (reg_addr)
                    OFS_TIMING1: st_next.mrd = reg_wdata[3:0];
                    OFS_TIMING2: {st_next.rfc, st_next.xsr} = reg_wdata;
                    OFS_TIMING3: {st_next.rp, st_next.wr} = reg_wdata;
                    OFS_TIMING4: {st_next.rcd, st_next.ras} = reg_wdata;
                    default: ;
                endcase
            end else begin
                unique case (reg_addr)
                    OFS_ATTR: st_next.attr = reg_wdata;
                    OFS_MODE: begin
                        if (!st_reg.mem_init_start_ready && !st_reg.init_req) begin
                            st_next.cas = reg_wdata[2:0];
                        end
                    end
                    OFS_REF_LO: st_next.refresh_interval[7:0] = reg_wdata;
                    OFS_REF_HI: st_next.refresh_interval[15:8] = reg_wdata;
                    default: ;
                endcase
            end
            if (reg_addr == OFS_CONTROL) begin
                st_next.timing_param_enable = reg_wdata[CTL_PEN];
                st_next.mem_power_save_request = reg_wdata[CTL_PSAVE];
                if (!reg_wdata[CTL_WARN]) begin
                    st_next.warn = 1'b0;
                end
                // Writing zero does nothing; one only once
                if (reg_wdata[CTL_INIT] && !st_reg.init_req) begin
                    st_next.init_req = 1'b1;
                end
            end
        end
        // Set beats a same-cycle clear
        if ((rd_valid && near_top) || bw_short) begin
            st_next.warn = 1'b1;
        end
        unique case (st_reg.state)
            SDT_IDLE: begin
                if (st_reg.init_req) begin
                    st_next.state = SDT_WAIT;
                    dly_load = 1'b1;
                    dly_count = 16'(INIT_WAIT_CYC);
                end
            end
            SDT_WAIT: begin
                if (!dly_busy) begin
                    st_next.state = SDT_PRE;
                    st_next.cmd = SDT_CMD_PRE;
                    dly_load = 1'b1;
                    dly_count = 16'(sdt_cycles(st_reg.rp));
                    st_next.aref_left = 2'(INIT_REFRESHES);
                end
            end
            SDT_PRE, SDT_AREF: begin
                if (!dly_busy) begin
                    if (st_reg.aref_left != 2'h0) begin
                        st_next.state = SDT_AREF;
                        st_next.cmd = SDT_CMD_REF;
                        st_next.aref_left = st_reg.aref_left - 2'h1;
                        dly_load = 1'b1;
                        dly_count = 16'(sdt_cycles(st_reg.rfc));
                    end else begin
                        st_next.state = SDT_LMR;
                        st_next.cmd = SDT_CMD_LMR;
                        dly_load = 1'b1;
                        dly_count = 16'(sdt_cycles(st_reg.mrd));
                    end
                end
            end
            SDT_LMR: begin
                if (!dly_busy) begin
                    st_next.state = SDT_RUN;
                    st_next.mem_init_start_ready = 1'b1;
                    st_next.ref_cnt = st_reg.refresh_interval;
                end
            end
            SDT_RUN: begin
                // Counts through command gaps, else busy time stretches spacing
                if (!st_reg.saving && st_reg.ref_cnt > 16'h0001) begin
                    st_next.ref_cnt = st_reg.ref_cnt - 16'h0001;
                end
                if (!dly_busy) begin
                    if (st_reg.mem_power_save_request && !st_reg.saving) begin
                        st_next.saving = 1'b1;
                        st_next.cmd = SDT_CMD_SREF;
                        // One idle cycle so exit never follows entry directly
                        dly_load = 1'b1;
                        dly_count = 16'h0001;
                    end else if (!st_reg.mem_power_save_request && st_reg.saving) begin
                        st_next.saving = 1'b0;
                        st_next.cmd = SDT_CMD_SEXIT;
                        dly_load = 1'b1;
                        dly_count = 16'(sdt_cycles(st_reg.xsr));
                        st_next.ref_cnt = st_reg.refresh_interval;
                    end else if (!st_reg.saving && st_reg.refresh_interval != 16'h0000
                        && st_reg.ref_cnt <= 16'h0001) begin
                        // Zero interval stops automatic refresh
                        st_next.cmd = SDT_CMD_REF;
                        st_next.ref_cnt = st_reg.refresh_interval;
                        dly_load = 1'b1;
                        dly_count = 16'(sdt_cycles(st_reg.rfc));
                    end
                end
            end
            default: st_next.state = SDT_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '{mrd: RST_MRD, rfc: RST_RFC, xsr: RST_XSR, rp: RST_RP, wr: RST_WR,
                rcd: RST_RCD, ras: RST_RAS, attr: RST_ATTR, cas: RST_CAS,
                refresh_interval: RST_REF, state: SDT_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end
    assign reg_rdata = st_reg.rdata;
    assign mem_cmd = st_reg.cmd;
    assign mem_cke = !st_reg.saving;
    assign mem_ready = st_reg.mem_init_start_ready && !st_reg.saving;
    // Column-path timings left to the access sequencer
    assign t_rcd = st_reg.rcd;
    assign t_ras = st_reg.ras;
    assign t_wr = st_reg.wr;
    assign cas_latency_select = st_reg.cas;
endmodule

// *** sdt_pkg.sv ***
// Package for the display memory control and timing register block.
// Assumes an 8-bit register port on a single 25 MHz clock.
package sdt_pkg;
    localparam logic [7:0] OFS_TIMING1 = 8'hE0;
    localparam logic [7:0] OFS_TIMING2 = 8'hE1;
    localparam logic [7:0] OFS_TIMING3 = 8'hE2;
    localparam logic [7:0] OFS_TIMING4 = 8'hE3;
    localparam logic [7:0] OFS_CONTROL = 8'hE4;
    localparam logic [7:0] OFS_ATTR = 8'hE0;
    localparam logic [7:0] OFS_MODE = 8'hE1;
    localparam logic [7:0] OFS_REF_LO = 8'hE2;
    localparam logic [7:0] OFS_REF_HI = 8'hE3;
    localparam logic [7:0] OFS_STATUS = 8'hE5;
    localparam logic [7:0] OFS_ATTR_EXT = 8'hE6;
    localparam int CTL_INIT = 0;
    localparam int CTL_PSAVE = 1;
    localparam int CTL_PEN = 2;
    localparam int CTL_WARN = 3;
    localparam int FLD_LO = 0;
    localparam int FLD_HI = 4;
    localparam logic [3:0] RST_MRD = 4'h2;
    localparam logic [3:0] RST_RFC = 4'h8;
    localparam logic [3:0] RST_XSR = 4'h7;
    localparam logic [3:0] RST_RP = 4'h2;
    localparam logic [3:0] RST_WR = 4'h0;
    localparam logic [3:0] RST_RCD = 4'h2;
    localparam logic [3:0] RST_RAS = 4'h6;
    localparam logic [7:0] RST_ATTR = 8'h29;
    localparam logic [2:0] RST_CAS = 3'h3;
    localparam logic [15:0] RST_REF = 16'h0000;
    localparam logic [15:0] REF_RECOMMENDED = 16'h061A;
    localparam int WARN_MARGIN_BYTES = 512;
    localparam int INIT_WAIT_NS = 200;
    localparam int CLK_PERIOD_NS = 40;
    localparam int INIT_WAIT_CYC = (INIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_REFRESHES = 2;
    typedef enum logic [5:0] {
        SDT_IDLE = 6'h01,
        SDT_WAIT = 6'h02,
        SDT_PRE = 6'h04,
        SDT_AREF = 6'h08,
        SDT_LMR = 6'h10,
        SDT_RUN = 6'h20
    } sdt_state_e;
    typedef enum logic [2:0] {
        SDT_CMD_NOP = 3'h0,
        SDT_CMD_PRE = 3'h1,
        SDT_CMD_REF = 3'h2,
        SDT_CMD_LMR = 3'h3,
        SDT_CMD_SREF = 3'h4,
        SDT_CMD_SEXIT = 3'h5
    } sdt_cmd_e;
    function automatic logic [4:0] sdt_cycles(input logic [3:0] fld);
        return {1'b0, fld} + 5'h01;
    endfunction
endpackage

// *** sdt_delay.sv ***
// Down-counter that spaces SDRAM commands by a programmed count.
// Assumes the load count is at least one.
`timescale 1ns/1ns
module sdt_delay #(
    parameter int W = 16
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic busy
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } sdt_dly_s;
    sdt_dly_s st_reg;
    sdt_dly_s st_next;
    initial begin
        if (W < 5) $error("sdt_delay width too small");
    end
    always_comb begin
        st_next = st_reg;
        if (load) begin
            st_next.cnt = count;
        end else if (st_reg.cnt != '0) begin
            st_next.cnt = st_reg.cnt - W'(1);
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    // Blocks the next command until zero
    assign busy = (st_reg.cnt != '0);
endmodule

// *** sdt_ctrl_properties.sv ***
// Port-level checks for the display memory control block.
// Bound to every sdt_ctrl; sees its ports only.
`timescale 1ns/1ns
module sdt_ctrl_properties
    import sdt_pkg::*;
#(
    parameter int ADDR_W = 24,
    parameter logic [ADDR_W-1:0] MEM_TOP = 24'hFFFFFF
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic rd_valid,
    input wire logic [ADDR_W-1:0] rd_addr,
    input wire logic bw_short,
    input wire logic [2:0] mem_cmd,
    input wire logic mem_cke,
    input wire logic mem_ready,
    input wire logic [3:0] t_rcd,
    input wire logic [3:0] t_ras,
    input wire logic [3:0] t_wr,
    input wire logic [2:0] cas_latency_select
);
    logic pen_reg;
    logic pen_next;
    // Mirror of the enable bit, since E3h means two things
    always_comb pen_next = (reg_wr && reg_addr == OFS_CONTROL) ? reg_wdata[CTL_PEN] : pen_reg;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) pen_reg <= 1'b0;
        else pen_reg <= pen_next;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    sequence s_cmd(logic [2:0] c);
        mem_cmd == c;
    endsequence
    cmd_gap_a: assert property (mem_cmd != SDT_CMD_NOP |=> s_cmd(SDT_CMD_NOP))
        else $error("commands back to back");
    sref_cke_a: assert property (s_cmd(SDT_CMD_SREF) |-> ##[0:2] !mem_cke)
        else $error("clock enable stays high in saving");
    save_ready_a: assert property (!mem_cke |-> !mem_ready)
        else $error("ready while saving");
    sexit_cmd_a: assert property (reg_wr && reg_addr == OFS_CONTROL && !reg_wdata[CTL_PSAVE]
        && !mem_cke |-> ##[1:4] s_cmd(SDT_CMD_SEXIT))
        else $error("no exit command");
    lmr_ready_a: assert property (s_cmd(SDT_CMD_LMR) |-> ##[1:20] mem_ready)
        else $error("ready late after mode load");
    rcd_ras_a: assert property (reg_wr && reg_addr == OFS_TIMING4 && pen_reg
        |=> {t_rcd, t_ras} == $past(reg_wdata))
        else $error("activate timing not taken");
    closed_a: assert property (reg_wr && reg_addr == OFS_TIMING4 && !pen_reg
        |=> $stable(t_rcd) && $stable(t_ras))
        else $error("timing written while closed");
    cas_lock_a: assert property (mem_ready |=> $stable(cas_latency_select))
        else $error("latency changed after init");
endmodule

bind sdt_ctrl sdt_ctrl_properties #(.ADDR_W(ADDR_W), .MEM_TOP(MEM_TOP)) i_props (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rd_valid(rd_valid), .rd_addr(rd_addr),
    .bw_short(bw_short), .mem_cmd(mem_cmd), .mem_cke(mem_cke), .mem_ready(mem_ready),
    .t_rcd(t_rcd), .t_ras(t_ras), .t_wr(t_wr), .cas_latency_select(cas_latency_select));

// *** sdt_mem_model.sv ***
// Memory array stand-in: counts commands, feeds display reads.
// Assumes the bench asks for reads and shortfall by level.
`timescale 1ns/1ns
module sdt_mem_model
    import sdt_pkg::*;
#(parameter int ADDR_W = 24) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [2:0] mem_cmd,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_req_addr,
    input wire logic bw_req,
    output logic rd_valid = 1'b0,
    output logic [ADDR_W-1:0] rd_addr = '0,
    output logic bw_short = 1'b0
);
    int n_cmd [8] = '{default: 0};
    int cyc = 0;
    int last_ref = 0;
    int ref_gap = 0;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        rd_valid <= rd_req & nrst;
        // Idle address toggles so a stale value never looks valid
        rd_addr <= rd_req ? rd_req_addr : ~rd_addr;
        bw_short <= bw_req & nrst;
        if (mem_cmd != 3'h0) n_cmd[mem_cmd] <= n_cmd[mem_cmd] + 1;
        if (mem_cmd == SDT_CMD_REF) begin
            ref_gap <= cyc - last_ref;
            last_ref <= cyc;
        end
    end
endmodule

// *** tb.sv ***
// Self-checking bench for the display memory control block.
// Drives the register port; the memory model sits on the far side.
`timescale 1ns/1ns
module tb;
    import sdt_pkg::*;
    localparam logic [23:0] TOP = 24'hFFFFFF;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_req = 1'b0;
    logic bw_req = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [23:0] req_addr = 24'h000000;
    logic [7:0] reg_rdata;
    logic [23:0] rd_addr;
    logic rd_valid, bw_short, mem_cke, mem_ready;
    logic [2:0] mem_cmd, cas;
    logic [3:0] t_rcd, t_ras, t_wr;
    int n_fail = 0;
    int check_count = 0;
    int snap;
    always #20 sys_clk = ~sys_clk;
    sdt_ctrl i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rd_valid(rd_valid),
        .rd_addr(rd_addr), .bw_short(bw_short), .mem_cmd(mem_cmd), .mem_cke(mem_cke),
        .mem_ready(mem_ready), .t_rcd(t_rcd), .t_ras(t_ras), .t_wr(t_wr),
        .cas_latency_select(cas));
    sdt_mem_model i_mem (.sys_clk(sys_clk), .nrst(nrst), .mem_cmd(mem_cmd), .rd_req(rd_req),
        .rd_req_addr(req_addr), .bw_req(bw_req), .rd_valid(rd_valid), .rd_addr(rd_addr),
        .bw_short(bw_short));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, {8'h00, reg_rdata}, {8'h00, exp});
    endtask
    task automatic wait_ready(input logic exp);
        repeat (300) begin
            if (mem_ready !== exp) begin
                @(posedge sys_clk);
                #1;
            end
        end
        // One settled cycle so the model has counted the last command
        @(posedge sys_clk);
        #1;
        chk("ready", {15'h0000, mem_ready}, {15'h0000, exp});
    endtask
    task automatic feed(input logic [23:0] a, input logic bw);
        @(posedge sys_clk);
        rd_req <= !bw;
        req_addr <= a;
        bw_req <= bw;
        cycles(3);
        rd_req <= 1'b0;
        bw_req <= 1'b0;
        cycles(3);
    endtask
    task automatic t_regs;
        rdc("control", OFS_CONTROL, 8'h00);
        rdc("unmapped", 8'h10, 8'h00);
        rdc("attr", OFS_ATTR, RST_ATTR);
        chk("fields", {4'h0, t_wr, t_rcd, t_ras}, {4'h0, RST_WR, RST_RCD, RST_RAS});
        wr(OFS_CONTROL, 8'h04);
        rdc("t1", OFS_TIMING1, {4'h0, RST_MRD});
        rdc("t2", OFS_TIMING2, {RST_RFC, RST_XSR});
        rdc("t3", OFS_TIMING3, {RST_RP, RST_WR});
        rdc("t4", OFS_TIMING4, {RST_RCD, RST_RAS});
        wr(OFS_TIMING1, 8'hFF);
        rdc("t1 top", OFS_TIMING1, 8'h0F);
        wr(OFS_TIMING1, 8'h02);
        wr(OFS_TIMING4, 8'hA5);
        wr(OFS_TIMING3, 8'h2B);
        chk("written", {4'h0, t_wr, t_rcd, t_ras}, 16'h0BA5);
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_ATTR, 8'h5A);
        rdc("attr w", OFS_ATTR, 8'h5A);
        wr(OFS_MODE, 8'h02);
        chk("cas", {13'h0000, cas}, 16'h0002);
        rdc("ref hi", OFS_REF_HI, 8'h00);
        wr(OFS_REF_HI, REF_RECOMMENDED[15:8]);
        wr(OFS_REF_LO, REF_RECOMMENDED[7:0]);
        rdc("ref lo", OFS_REF_LO, 8'h1A);
        chk("closed", {8'h00, t_rcd, t_ras}, 16'h00A5);
    endtask
    task automatic t_init;
        wr(OFS_CONTROL, 8'h01);
        rdc("pending", OFS_CONTROL, 8'h00);
        wait_ready(1'b1);
        chk("sequence", 16'(i_mem.n_cmd[SDT_CMD_PRE] * 16 + i_mem.n_cmd[SDT_CMD_REF] * 4
            + i_mem.n_cmd[SDT_CMD_LMR]), 16'h0019);
        rdc("ready", OFS_CONTROL, 8'h01);
        rdc("status", OFS_STATUS, {2'h0, SDT_RUN});
        wr(OFS_CONTROL, 8'h00);
        rdc("sticky", OFS_CONTROL, 8'h01);
        chk("no rerun", 16'(i_mem.n_cmd[SDT_CMD_PRE]), 16'h0001);
        wr(OFS_MODE, 8'h03);
        chk("cas lock", {13'h0000, cas}, 16'h0002);
    endtask
    task automatic t_refresh;
        wr(OFS_REF_HI, 8'h00);
        wr(OFS_REF_LO, 8'h20);
        // Count left from the init-time interval runs out first
        cycles(1700);
        chk("ref gap", 16'(i_mem.ref_gap), 16'h0020);
        wr(OFS_REF_LO, 8'h00);
        cycles(40);
        snap = i_mem.n_cmd[SDT_CMD_REF];
        cycles(200);
        chk("no refresh", 16'(i_mem.n_cmd[SDT_CMD_REF] - snap), 16'h0000);
    endtask
    task automatic t_psave;
        wr(OFS_CONTROL, 8'h03);
        cycles(20);
        chk("saving", {14'h0000, mem_cke, mem_ready}, 16'h0000);
        wr(OFS_CONTROL, 8'h01);
        wait_ready(1'b1);
        chk("edges", 16'(i_mem.n_cmd[4] * 16 + i_mem.n_cmd[5]), 16'h0011);
    endtask
    task automatic t_warn;
        feed(TOP - 24'h000200, 1'b0);
        rdc("margin", OFS_CONTROL, 8'h01);
        feed(TOP - 24'h0001FF, 1'b0);
        rdc("near top", OFS_CONTROL, 8'h09);
        wr(OFS_CONTROL, 8'h01);
        rdc("cleared", OFS_CONTROL, 8'h01);
        feed(24'h000000, 1'b1);
        rdc("bandwidth", OFS_CONTROL, 8'h09);
    endtask
    initial begin
        cycles(10);
        nrst <= 1'b1;
        t_regs;
        t_init;
        t_refresh;
        t_psave;
        t_warn;
        stop_test;
    end
    initial begin
        cycles(20000);
        n_fail++;
        stop_test;
    end
endmodule
